// ---- qbd_dev.sv ----
`timescale 1ns/1ps
`default_nettype none

// =======================================================================
// Write line FIFO between the pin side and the array
module qbd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = qbd_pkg::FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointer width; depth must be a power of two
  localparam int PTR_W = $clog2(DEPTH);

  // Pointers with one wrap bit each
  typedef struct packed {
    logic [PTR_W:0] wr_ptr;
    logic [PTR_W:0] rd_ptr;
  } qbd_fifo_state_t;

  qbd_fifo_state_t st;
  qbd_fifo_state_t next_st;
  // Storage words
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full when wrap bits differ and indices match
  assign in_ready = (st.wr_ptr[PTR_W] == st.rd_ptr[PTR_W]) ||
                    (st.wr_ptr[PTR_W-1:0] != st.rd_ptr[PTR_W-1:0]);
  // Empty when pointers are equal
  assign out_valid = st.wr_ptr != st.rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rd_ptr[PTR_W-1:0]];

  // Pointer advance
  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = (PTR_W+1)'(st.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_st.rd_ptr = (PTR_W+1)'(st.rd_ptr + 1'b1);
    end
  end

  // Pointer registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st.wr_ptr[PTR_W-1:0]] <= in_data;
    end
  end
endmodule

// =======================================================================
// Device side command, address and data interface
module qbd_dev (
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_clock,
  input wire logic clock_complement,
  input wire logic clock_enable,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_enable_n,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [qbd_pkg::ADDR_W-1:0] address,
  input wire logic [qbd_pkg::DQ_W-1:0] dq_in,
  output logic [qbd_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [qbd_pkg::LANES-1:0] write_byte_strobe,
  input wire logic [qbd_pkg::LANES-1:0] write_byte_mask,
  output logic [qbd_pkg::LANES-1:0] read_byte_strobe,
  output logic read_strobe_oe,
  input wire logic [1:0] write_latency,
  input wire logic burst_interleave,
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output qbd_pkg::qbd_wline_t arr_wr,
  output logic arr_rd_req,
  output qbd_pkg::qbd_loc_t arr_rd_loc,
  input wire logic arr_rd_valid,
  input wire logic [qbd_pkg::LINE_W-1:0] arr_rd_data,
  output logic arr_refresh,
  output logic [qbd_pkg::BANKS-1:0] bank_open,
  output logic self_refresh,
  output logic protocol_error,
  output logic write_overrun
);
  // Module state apart from the write FIFO and the check counters
  typedef struct packed {
    qbd_pkg::qbd_pins_t sync1;
    qbd_pkg::qbd_pins_t sync2;
    logic ck_prev;
    logic [qbd_pkg::LANES-1:0] ws_prev;
    logic [qbd_pkg::BANKS-1:0] open;
    logic [qbd_pkg::BANKS-1:0][qbd_pkg::ROW_W-1:0] rows;
    qbd_pkg::qbd_wst_t wst;
    logic [1:0] wl_cnt;
    logic wap;
    logic [qbd_pkg::LANES-1:0][2:0] wbeat;
    qbd_pkg::qbd_wline_t wline;
    logic wpend;
    qbd_pkg::qbd_rst_t rst;
    qbd_pkg::qbd_loc_t rloc;
    logic rap;
    logic rgot;
    logic [1:0] rbeat;
    logic [qbd_pkg::LINE_W-1:0] rline;
    logic rd_req;
    logic refresh;
    logic perr;
    logic overrun;
    logic [qbd_pkg::DQ_W-1:0] dq;
    logic oe;
    logic [qbd_pkg::LANES-1:0] rstrobe;
    logic self_ref;
    logic [qbd_pkg::SR_TIMER_W-1:0] sr_timer;
  } qbd_dev_state_t;

  qbd_dev_state_t st;
  qbd_dev_state_t next_st;
  qbd_pkg::qbd_pins_t pins_now; // Raw pin bundle
  logic ck_lvl;                  // Differential clock level
  logic ck_rise;
  logic ck_edge;
  logic cmd_sel;                 // Rising edge with chip selected
  logic [2:0] cmd;
  logic [qbd_pkg::BANK_W-1:0] cbank;
  logic [qbd_pkg::ADDR_W-1:0] caddr;
  logic act_fire;
  logic rd_fire;
  logic wr_fire;
  logic pre_fire;
  logic ref_fire;
  logic sr_enter;
  logic [qbd_pkg::LANES-1:0] ws_edge; // Write strobe edges per lane
  logic fifo_ready;

  // Beat slot within the aligned line for beat k
  function automatic logic [1:0] slot_of(input logic [1:0] start, input logic [1:0] k,
                                         input logic il);
    slot_of = il ? (start ^ k) : 2'(start + k);
  endfunction

  // =====================================================================
  // Pin capture and command decode
  assign pins_now = {mem_clock, clock_complement, clock_enable, chip_select_n, row_strobe_n,
                     column_strobe_n, write_enable_n, bank_select_hi, bank_select_lo,
                     address, dq_in, write_byte_strobe, write_byte_mask};
  assign ck_lvl = st.sync2.ck & ~st.sync2.ck_c;
  assign ck_rise = ck_lvl & ~st.ck_prev;
  assign ck_edge = ck_lvl ^ st.ck_prev;
  assign cmd_sel = ck_rise & ~st.sync2.cs_n;
  assign cmd = {st.sync2.ras_n, st.sync2.cas_n, st.sync2.we_n};
  assign cbank = st.sync2.bank;
  assign caddr = st.sync2.addr;
  assign act_fire = cmd_sel && st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_ACT;
  assign rd_fire = cmd_sel && st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_RD;
  assign wr_fire = cmd_sel && st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_WR;
  assign pre_fire = cmd_sel && st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_PRE;
  assign ref_fire = cmd_sel && st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_REF;
  assign sr_enter = cmd_sel && !st.sync2.cke && !st.self_ref && cmd == qbd_pkg::CMD_REF;

  // Per lane write strobe edge detect
  for (genvar l = 0; l < qbd_pkg::LANES; l++)
  begin : g_lane
    assign ws_edge[l] = st.sync2.wstrobe[l] ^ st.ws_prev[l];
  end

  // =====================================================================
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.sync1 = pins_now;
    next_st.sync2 = st.sync1;
    next_st.ck_prev = ck_lvl;
    next_st.ws_prev = st.sync2.wstrobe;
    next_st.rd_req = 1'b0;
    next_st.refresh = 1'b0;
    next_st.perr = 1'b0;
    next_st.overrun = 1'b0;

    // Handed-off line frees the assembler
    if (st.wpend && fifo_ready)
    begin
      next_st.wpend = 1'b0;
    end

    if (act_fire)
    begin
      if (st.open[cbank])
      begin
        next_st.perr = 1'b1;
      end
      else
      begin
        next_st.open[cbank] = 1'b1;
        next_st.rows[cbank] = caddr;
      end
    end

    // Precharge of one bank or all banks
    if (pre_fire)
    begin
      if (caddr[qbd_pkg::AP_BIT])
      begin
        next_st.open = '0;
      end
      else
      begin
        next_st.open[cbank] = 1'b0;
      end
    end

    if (rd_fire)
    begin
      if (!st.open[cbank] || st.rst != qbd_pkg::R_IDLE)
      begin
        next_st.perr = 1'b1;
      end
      else
      begin
        next_st.rst = qbd_pkg::R_WAIT;
        next_st.rgot = 1'b0;
        next_st.rd_req = 1'b1;
        next_st.rloc.bank = cbank;
        next_st.rloc.row = st.rows[cbank];
        next_st.rloc.col = {caddr[qbd_pkg::COL_HI_BIT], caddr[7:0]};
        next_st.rap = caddr[qbd_pkg::AP_BIT];
      end
    end

    if (wr_fire)
    begin
      if (st.wpend)
      begin
        next_st.overrun = 1'b1;
      end
      else if (!st.open[cbank] || st.wst != qbd_pkg::W_IDLE)
      begin
        next_st.perr = 1'b1;
      end
      else
      begin
        next_st.wst = qbd_pkg::W_LAT;
        next_st.wl_cnt = (write_latency == 2'h0) ? qbd_pkg::WL_MIN : write_latency;
        next_st.wbeat = '0;
        next_st.wline.loc.bank = cbank;
        next_st.wline.loc.row = st.rows[cbank];
        next_st.wline.loc.col = {caddr[qbd_pkg::COL_HI_BIT], caddr[7:0]};
        next_st.wline.data = '0;
        next_st.wline.mask = '1;
        next_st.wap = caddr[qbd_pkg::AP_BIT];
      end
    end

    // auto refresh or self refresh entry with all banks idle
    if (ref_fire || sr_enter)
    begin
      if (st.open != '0)
      begin
        next_st.perr = 1'b1;
      end
      else if (ref_fire)
      begin
        next_st.refresh = 1'b1;
      end
      else
      begin
        next_st.self_ref = 1'b1;
        next_st.sr_timer = '0;
      end
    end

    // self refresh keeps its own cadence
    if (st.self_ref)
    begin
      if (st.sync2.cke)
      begin
        next_st.self_ref = 1'b0;
      end
      else if (st.sr_timer == qbd_pkg::SR_TIMER_W'(qbd_pkg::REFRESH_CYCLES - 1))
      begin
        next_st.refresh = 1'b1;
        next_st.sr_timer = '0;
      end
      else
      begin
        next_st.sr_timer = qbd_pkg::SR_TIMER_W'(st.sr_timer + 1'b1);
      end
    end

    // Write burst sequencing
    unique case (st.wst)
      qbd_pkg::W_IDLE:
      begin
        next_st.wst = next_st.wst;
      end
      qbd_pkg::W_LAT:
      begin
        if (ck_rise)
        begin
          next_st.wl_cnt = 2'(st.wl_cnt - 1'b1);
          if (st.wl_cnt == qbd_pkg::WL_MIN)
          begin
            next_st.wst = qbd_pkg::W_DATA;
          end
        end
      end
      qbd_pkg::W_DATA:
      begin
        for (int l = 0; l < qbd_pkg::LANES; l++)
        begin
          if (ws_edge[l] && st.wbeat[l] != 3'(qbd_pkg::BURST_LEN))
          begin
            next_st.wline.data[int'(slot_of(st.wline.loc.col[1:0], st.wbeat[l][1:0],
              burst_interleave)) * qbd_pkg::DQ_W + l * 8 +: 8] = st.sync2.dq[l * 8 +: 8];
            next_st.wline.mask[int'(slot_of(st.wline.loc.col[1:0], st.wbeat[l][1:0],
              burst_interleave)) * qbd_pkg::LANES + l] = st.sync2.mask[l];
            next_st.wbeat[l] = 3'(st.wbeat[l] + 1'b1);
          end
        end
        if (next_st.wbeat == {qbd_pkg::LANES{3'(qbd_pkg::BURST_LEN)}})
        begin
          next_st.wst = qbd_pkg::W_IDLE;
          next_st.wpend = 1'b1;
          if (st.wap)
          begin
            next_st.open[st.wline.loc.bank] = 1'b0;
          end
        end
      end
    endcase

    // Read burst sequencing
    unique case (st.rst)
      qbd_pkg::R_IDLE:
      begin
        next_st.oe = 1'b0;
      end
      qbd_pkg::R_WAIT:
      begin
        if (arr_rd_valid && !st.rgot)
        begin
          next_st.rline = arr_rd_data;
          next_st.rgot = 1'b1;
        end
        if (st.rgot && ck_edge)
        begin
          next_st.dq = st.rline[int'(slot_of(st.rloc.col[1:0], 2'h0, burst_interleave))
                                * qbd_pkg::DQ_W +: qbd_pkg::DQ_W];
          next_st.rstrobe = '1;
          next_st.oe = 1'b1;
          next_st.rbeat = 2'h1;
          next_st.rst = qbd_pkg::R_DRIVE;
        end
      end
      qbd_pkg::R_DRIVE:
      begin
        if (ck_edge && st.rbeat == 2'h0)
        begin
          next_st.oe = 1'b0;
          next_st.rstrobe = '0;
          next_st.rst = qbd_pkg::R_IDLE;
          if (st.rap)
          begin
            next_st.open[st.rloc.bank] = 1'b0;
          end
        end
        else if (ck_edge)
        begin
          next_st.dq = st.rline[int'(slot_of(st.rloc.col[1:0], st.rbeat, burst_interleave))
                                * qbd_pkg::DQ_W +: qbd_pkg::DQ_W];
          next_st.rstrobe = {qbd_pkg::LANES{~st.rbeat[0]}};
          next_st.rbeat = 2'(st.rbeat + 1'b1);
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.wst <= qbd_pkg::W_IDLE;
      st.rst <= qbd_pkg::R_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // =====================================================================
  // Write line buffer towards the array
  qbd_fifo #(
    .WIDTH($bits(qbd_pkg::qbd_wline_t)),
    .DEPTH(qbd_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk(clk),
    .reset(reset),
    .in_valid(st.wpend),
    .in_ready(fifo_ready),
    .in_data(st.wline),
    .out_valid(arr_wr_valid),
    .out_ready(arr_wr_ready),
    .out_data(arr_wr)
  );

  // Outputs from state
  assign dq_out = st.dq;
  assign dq_oe = st.oe;
  assign read_byte_strobe = st.rstrobe;
  assign read_strobe_oe = st.oe;
  assign arr_rd_req = st.rd_req;
  assign arr_rd_loc = {st.rloc.bank, st.rloc.row, st.rloc.col[qbd_pkg::COL_W-1:2], 2'h0};
  assign arr_refresh = st.refresh;
  assign bank_open = st.open;
  assign self_refresh = st.self_ref;
  assign protocol_error = st.perr;
  assign write_overrun = st.overrun;

  // =====================================================================
  // Checks
  logic [2:0] edge_cnt;                         // Clock edges seen while driving
  logic [qbd_pkg::SR_TIMER_W:0] sr_gap;         // Cycles since last refresh in self refresh

  // Helper counters for the checks
  always_ff @(posedge clk)
  begin
    if (reset || !st.oe)
    begin
      edge_cnt <= '0;
    end
    else if (ck_edge)
    begin
      edge_cnt <= 3'(edge_cnt + 1'b1);
    end
    if (reset || !st.self_ref || st.refresh)
    begin
      sr_gap <= '0;
    end
    else
    begin
      sr_gap <= (qbd_pkg::SR_TIMER_W+1)'(sr_gap + 1'b1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_ACT_OPEN: assert property (act_fire && !st.open[cbank] |=>
    st.open[$past(cbank)] && st.rows[$past(cbank)] == $past(caddr))
    else $error("activate did not open the row");
  AST_CLOSED_BANK: assert property (rd_fire && !st.open[cbank] |=>
    protocol_error && !arr_rd_req)
    else $error("read to closed bank not refused");
  AST_COL_ADDR: assert property (rd_fire && st.open[cbank] && st.rst == qbd_pkg::R_IDLE |=>
    arr_rd_req && arr_rd_loc.col[qbd_pkg::COL_W-1:2] == {$past(caddr[9]), $past(caddr[7:2])})
    else $error("read column taken from wrong pins");
  AST_BURST_FOUR: assert property ($fell(st.oe) |-> $past(edge_cnt) == 3'h3)
    else $error("read burst not four beats");
  AST_PREFETCH: assert property (arr_rd_req |=> !arr_rd_req)
    else $error("array read more than once per two cycles");
  AST_CMD_EDGE: assert property (arr_rd_req |-> $past(ck_rise))
    else $error("command taken off the rising edge");
  AST_CS_MASK: assert property (ck_rise && st.sync2.cs_n |=>
    !arr_rd_req && !protocol_error)
    else $error("command decoded with chip deselected");
  AST_AP_CLOSE: assert property ($fell(st.oe) && st.rap |-> !st.open[st.rloc.bank])
    else $error("auto precharge left bank open");
  AST_WL_WAIT: assert property (st.wst == qbd_pkg::W_LAT && !ck_rise |=>
    st.wst != qbd_pkg::W_DATA)
    else $error("write data window opened early");
  AST_SR_GAP: assert property (sr_gap <= qbd_pkg::REFRESH_CYCLES)
    else $error("self refresh interval too long");

  COV_ACT: cover property (act_fire && !st.open[cbank]);
  COV_READ: cover property ($fell(st.oe));
  COV_WRITE: cover property (st.wpend && fifo_ready);
  COV_SELF_REF: cover property ($rose(st.self_ref));
endmodule

`default_nettype wire

// ---- qbd_pkg.sv ----
// Operation
// - Access needs activate, then column command
// - Activate latches bank and twelve-bit row
// - Column start from A0-A7 plus A9
// - Burst walks start column in programmed order
// - Burst length fixed at four words
// - Array moves 4n word per two cycles
// - Commands captured on rising memory clock
// - Read strobe edge aligned, write strobe centred
// - Masked write bytes are not stored
// - Write data follows programmed latency one-three
// - Auto refresh and self refresh both supported
// - Four banks, each with own open row
// - Auto precharge closes only its own bank
// - A8 on column command requests auto precharge
// - Commands decoded only with chip select low
// - Command from strobes, enable and select
package qbd_pkg;

  // =====================================================================
  // Geometry
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int ADDR_W = 12;
  localparam int COL_W = 9;
  localparam int AP_BIT = 8;
  localparam int COL_HI_BIT = 9;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int BURST_LEN = 4;
  localparam int LINE_W = DQ_W * BURST_LEN;
  localparam int MASK_W = LANES * BURST_LEN;
  localparam int FIFO_DEPTH = 16;

  // =====================================================================
  // Timing
  localparam longint CLK_PERIOD_PS = 4000;
  localparam longint REFRESH_WINDOW_MS = 32;
  localparam longint REFRESH_ROWS = 4096;
  // Longest spacing between refreshes, rounded down to whole cycles
  localparam int REFRESH_CYCLES =
    int'((REFRESH_WINDOW_MS * 64'd1000000000) / (REFRESH_ROWS * CLK_PERIOD_PS));
  localparam int SR_TIMER_W = 11;
  localparam logic [1:0] WL_MIN = 2'h1;

  // =====================================================================
  // Command codes as {row strobe, column strobe, write enable}, active low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // =====================================================================
  // State encodings
  typedef enum logic [2:0] {W_IDLE = 3'h1, W_LAT = 3'h2, W_DATA = 3'h4} qbd_wst_t;
  typedef enum logic [2:0] {R_IDLE = 3'h1, R_WAIT = 3'h2, R_DRIVE = 3'h4} qbd_rst_t;

  // =====================================================================
  // Carriers
  typedef struct packed {
    logic ck;
    logic ck_c;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] wstrobe;
    logic [LANES-1:0] mask;
  } qbd_pins_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } qbd_loc_t;

  typedef struct packed {
    qbd_loc_t loc;
    logic [LINE_W-1:0] data;
    logic [MASK_W-1:0] mask;
  } qbd_wline_t;

endpackage

// ---- qbd_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========
// Memory controller model on the pin side
module qbd_ctrl (
  output var qbd_pkg::qbd_pins_t pins
);
  // Idle pins, deselected
  initial
  begin
    pins = '0;
    pins.cke = 1'h1;
    pins.cs_n = 1'h1;
    {pins.ras_n, pins.cas_n, pins.we_n} = qbd_pkg::CMD_NOP;
  end

  // Free running differential memory clock, 48 ns
  always #24
  begin
    pins.ck = ~pins.ck;
    pins.ck_c = ~pins.ck;
  end

  task automatic cmd(input logic [2:0] code, input logic [1:0] bank, input logic [11:0] addr,
                     input logic cs_n);
    @(negedge pins.ck);
    pins.cs_n <= cs_n;
    {pins.ras_n, pins.cas_n, pins.we_n} <= code;
    pins.bank <= bank;
    pins.addr <= addr;
    @(negedge pins.ck);
    pins.cs_n <= 1'h1;
    {pins.ras_n, pins.cas_n, pins.we_n} <= qbd_pkg::CMD_NOP;
    pins.bank <= ~bank;
    pins.addr <= ~addr;
  endtask

  task automatic set_cke(input logic v);
    @(negedge pins.ck);
    pins.cke <= v;
  endtask

  task automatic wdata(input logic [1:0] wl, input logic [127:0] d, input logic [15:0] m);
    repeat (wl) @(posedge pins.ck);
    for (int k = 0; k < 4; k++)
    begin
      pins.dq <= d[k*32+:32];
      pins.mask <= m[k*4+:4];
      #12;
      pins.wstrobe <= ~pins.wstrobe;
      #12;
    end
    // Released bus shows no stale data
    pins.dq <= ~d[127:96];
    pins.mask <= 4'h0;
  endtask
endmodule

`default_nettype wire

// ---- qbd_dev_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========
// Bench for the device interface
module qbd_dev_tb;
  logic clk = 1'h0;
  logic reset = 1'h1;
  qbd_pkg::qbd_pins_t p;
  logic [31:0] dq_out;
  logic dq_oe, read_strobe_oe, arr_wr_valid, arr_rd_req, arr_refresh, self_refresh;
  logic protocol_error, write_overrun;
  logic [3:0] read_byte_strobe, bank_open;
  logic [1:0] write_latency = 2'h1;
  logic burst_interleave = 1'h0;
  logic arr_wr_ready = 1'h1;
  logic arr_rd_valid = 1'h0;
  logic [127:0] arr_rd_data = '0;
  qbd_pkg::qbd_wline_t arr_wr;
  qbd_pkg::qbd_loc_t arr_rd_loc;
  int mismatches = 0;
  int checks_done = 0;
  int perrs = 0;
  int refs = 0;
  int ovrs = 0;
  int reqs = 0;
  int cyc = 0;
  // Data wire resolved from both drivers
  wire logic [31:0] dq_wire = dq_oe ? dq_out : p.dq;

  always #2 clk = ~clk;

  qbd_dev i_qbd_dev (.clk, .reset, .mem_clock(p.ck), .clock_complement(p.ck_c),
    .clock_enable(p.cke), .chip_select_n(p.cs_n), .row_strobe_n(p.ras_n),
    .column_strobe_n(p.cas_n), .write_enable_n(p.we_n), .bank_select_lo(p.bank[0]),
    .bank_select_hi(p.bank[1]), .address(p.addr), .dq_in(dq_wire), .dq_out, .dq_oe,
    .write_byte_strobe(p.wstrobe), .write_byte_mask(p.mask), .read_byte_strobe,
    .read_strobe_oe, .write_latency, .burst_interleave, .arr_wr_valid, .arr_wr_ready,
    .arr_wr, .arr_rd_req, .arr_rd_loc, .arr_rd_valid, .arr_rd_data, .arr_refresh,
    .bank_open, .self_refresh, .protocol_error, .write_overrun);
  qbd_ctrl i_qbd_ctrl (.pins(p));

  // Pulse counters and run limit
  always @(posedge clk)
  begin
    cyc++;
    if (protocol_error === 1'h1)
      perrs++;
    if (arr_refresh === 1'h1)
      refs++;
    if (write_overrun === 1'h1)
      ovrs++;
    if (arr_rd_req === 1'h1)
      reqs++;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Open banks, refused commands, close all
  task automatic t_banks();
    int e;
    e = perrs;
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h0, 12'h123, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h3, 12'h456, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h1, 12'h789, 1'h1);
    tick(8);
    chk(bank_open, 4'h9, "open banks");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h0, 12'h123, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_RD, 2'h2, 12'h000, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_REF, 2'h0, 12'h000, 1'h0);
    tick(8);
    chk(perrs - e, 3, "refusals");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_PRE, 2'h0, 12'h100, 1'h0);
    tick(8);
    chk(bank_open, 4'h0, "close all");
  endtask

  // Masked write burst at one latency
  task automatic t_write(input logic [1:0] wl);
    logic [127:0] d;
    logic [127:0] ed;
    logic [15:0] em;
    int s;
    int n;
    em = 16'h0;
    for (int k = 0; k < 4; k++)
    begin
      d[k*32+:32] = {8'(wl), 8'(k), 16'h5aa5};
      s = (wl == 2'h3) ? (wl ^ k) : ((wl + k) % 4);
      ed[s*32+:32] = d[k*32+:32];
    end
    em[wl*4+1] = 1'h1;
    @(posedge clk);
    write_latency <= wl;
    burst_interleave <= (wl == 2'h3);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h2, 12'habc, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_WR, 2'h2, {2'h0, 2'h3, 6'h05, wl}, 1'h0);
    i_qbd_ctrl.wdata(wl, d, 16'h0002);
    n = 0;
    while (arr_wr_valid !== 1'h1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(arr_wr.loc, {2'h2, 12'habc, 1'h1, 6'h05, wl}, "write place");
    chk(arr_wr.mask, em, "write mask");
    for (int b = 0; b < 16; b++)
      if (!em[b])
        chk(arr_wr.data[b*8+:8], ed[b*8+:8], "write byte");
    tick(20);
    chk(bank_open, 4'h0, "auto close");
  endtask

  // Read burst with another bank left open
  task automatic t_read(input logic il);
    logic [127:0] line;
    int n;
    int e;
    for (int k = 0; k < 4; k++)
      line[k*32+:32] = {16'hbeef, 7'h0, il, 8'(k)};
    e = reqs;
    @(posedge clk);
    burst_interleave <= il;
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h3, 12'h5c3, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h1, 12'h0f0, 1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_RD, 2'h3, 12'h103, 1'h0);
    // The request pulse has passed before the command task returns
    chk(reqs - e, 1, "read request");
    chk(arr_rd_loc, {2'h3, 12'h5c3, 9'h000}, "read place");
    @(posedge clk);
    arr_rd_valid <= 1'h1;
    arr_rd_data <= line;
    @(posedge clk);
    arr_rd_valid <= 1'h0;
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      while (!(dq_oe === 1'h1 && read_byte_strobe === {4{~k[0]}}) && n < 100)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(dq_out, line[(il ? (3 ^ k) : ((3 + k) % 4))*32+:32], "read beat");
      chk(read_strobe_oe, 1'h1, "strobe drive");
    end
    tick(40);
    chk({dq_oe, bank_open}, 5'h02, "read end");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_PRE, 2'h0, 12'h100, 1'h0);
  endtask

  // Auto refresh, then self refresh timer
  task automatic t_refresh();
    int e;
    e = refs;
    i_qbd_ctrl.cmd(qbd_pkg::CMD_REF, 2'h0, 12'h000, 1'h0);
    tick(8);
    chk(refs - e, 1, "auto refresh");
    i_qbd_ctrl.set_cke(1'h0);
    i_qbd_ctrl.cmd(qbd_pkg::CMD_REF, 2'h0, 12'h000, 1'h0);
    tick(8);
    e = refs;
    chk(self_refresh, 1'h1, "self entry");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h0, 12'h001, 1'h0);
    tick(2100);
    chk({bank_open, 8'(refs - e)}, 12'h001, "self period");
    i_qbd_ctrl.set_cke(1'h1);
    tick(8);
    chk(self_refresh, 1'h0, "self exit");
  endtask

  // Fill the write buffer through the pins until a write is refused, then drain
  task automatic t_fifo();
    int e;
    e = ovrs;
    @(posedge clk);
    // Latency code zero behaves as one
    write_latency <= 2'h0;
    arr_wr_ready <= 1'h0;
    i_qbd_ctrl.cmd(qbd_pkg::CMD_ACT, 2'h0, 12'h011, 1'h0);
    for (int i = 0; i < 17; i++)
    begin
      i_qbd_ctrl.cmd(qbd_pkg::CMD_WR, 2'h0, 12'h000, 1'h0);
      i_qbd_ctrl.wdata(2'h1, {4{32'(i)}}, 16'h0);
    end
    tick(8);
    chk({arr_wr_valid, 8'(ovrs - e)}, 9'h100, "buffer room");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_WR, 2'h0, 12'h000, 1'h0);
    tick(8);
    chk(ovrs - e, 1, "buffer full");
    @(posedge clk);
    arr_wr_ready <= 1'h1;
    for (int j = 0; j < 17; j++)
    begin
      #1;
      chk({arr_wr_valid, arr_wr.data[31:0]}, {1'h1, 32'(j)}, "buffer order");
      @(posedge clk);
    end
    #1;
    chk(arr_wr_valid, 1'h0, "buffer empty");
    i_qbd_ctrl.cmd(qbd_pkg::CMD_PRE, 2'h0, 12'h100, 1'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    tick(4);
    t_banks();
    for (int w = 1; w < 4; w++)
      t_write(2'(w));
    t_read(1'h0);
    t_read(1'h1);
    t_refresh();
    t_fifo();
    finish_test();
  end
endmodule

`default_nettype wire
